// file: verilog/adsq_control.sv
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
// Operation
// RULE_01 - Resolution is 8 or 10 bits, picked by a mode bit.
// RULE_02 - Each result goes to the shared register and its channel register.
// RULE_03 - External trigger source starts a sequence on a pin rising edge.
// RULE_04 - Software start or timer outputs 0 to 2 may also trigger.
// RULE_05 - Device drives the 4-to-1 input multiplexer select.
// RULE_06 - Channels enabled one by one; only enabled ones are converted.
// RULE_07 - Sleep mode wakes on trigger, converts all enabled, sleeps again.
// RULE_08 - Status register bits 0..3 show which channels are enabled.
// RULE_09 - Results are handed to a DMA channel without processor help.
// RULE_10 - Configurable startup and sample-and-hold delays precede conversions.
// RULE_11 - Only the selected source triggers; triggers during a sequence ignored.
module adsq_control
    import adsq_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Trigger pins
    input wire logic ext_conv_trigger_pin,
    input wire logic timer0_output_a,
    input wire logic timer1_output_a,
    input wire logic timer2_output_a,
    // Converter core
    output logic [1:0] core_mux_select,
    output logic core_power_on,
    output logic core_sample,
    output logic core_start,
    input wire logic core_done,
    input wire logic [9:0] core_data,
    // Peripheral DMA channel
    output logic peripheral_dma_channel_valid,
    input wire logic peripheral_dma_channel_ready,
    output logic [11:0] peripheral_dma_channel_data
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_STARTUP = 6'b00_0010,
        ST_SELECT = 6'b00_0100,
        ST_SAMPLE = 6'b00_1000,
        ST_CONVERT = 6'b01_0000,
        ST_STORE = 6'b10_0000
    } adsq_state_t;

    adsq_state_t state;
    logic [31:0] mode;
    logic [NUM_CHANNELS-1:0] chan_en;
    logic [9:0] last_result;
    logic [1:0] last_chan;
    logic [9:0] chan_result [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] pending;
    logic [1:0] cur_chan;
    logic [11:0] delay_cnt;
    logic sw_start;
    logic sw_reset;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_rise;
    logic trig_sel;
    logic trigger;
    logic overrun;
    logic [9:0] next_result;
    logic fifo_in_ready;
    logic fifo_pop;
    logic [11:0] fifo_out_data;
    logic fifo_out_valid;
    logic wr_hit;
    logic rd_hold;

    // Two-flop synchronisers for pins, third stage for edge detection
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= {ext_conv_trigger_pin, timer2_output_a, timer1_output_a, timer0_output_a};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign pin_rise = pin_s2 & ~pin_s3;

    // Trigger source selection
    always_comb begin
        case (mode[MODE_TRG_SEL_LSB +: 3])
            TRG_TIMER0: trig_sel = pin_rise[0]; // RULE_04
            TRG_TIMER1: trig_sel = pin_rise[1]; // RULE_04
            TRG_TIMER2: trig_sel = pin_rise[2]; // RULE_04
            TRG_EXTERNAL: trig_sel = pin_rise[3]; // RULE_03
            default: trig_sel = 1'b0; // RULE_11
        endcase
    end
    // Hardware trigger when enabled, otherwise software start
    assign trigger = mode[MODE_TRG_EN_BIT] ? trig_sel : sw_start; // RULE_04

    // Bus decode; a read waits one cycle so its data stand when waitrequest drops
    assign avs_waitrequest = avs_read && !rd_hold;
    assign wr_hit = avs_write && (avs_byteenable != 4'h0);
    assign sw_start = wr_hit && (avs_address == OFS_CONTROL) && avs_writedata[CTL_START_BIT];
    assign sw_reset = wr_hit && (avs_address == OFS_CONTROL)
        && avs_writedata[CTL_SOFT_RESET_BIT];
    assign fifo_pop = avs_read && !rd_hold && (avs_address == OFS_FIFO_DATA);

    // Read wait state: set by the first cycle of a read, cleared at its acceptance
    always_ff @(posedge clock) begin
        if (reset) begin
            rd_hold <= 1'b0;
        end else begin
            rd_hold <= avs_read && !rd_hold;
        end
    end

    // Mode register with byte lanes
    always_ff @(posedge clock) begin
        if (reset || sw_reset) begin
            mode <= MODE_RESET;
        end else if (avs_write && avs_address == OFS_MODE) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b]) begin
                    mode[8*b +: 8] <= avs_writedata[8*b +: 8];
                end
            end
        end
    end

    // Channel enable set/clear
    always_ff @(posedge clock) begin
        if (reset || sw_reset) begin
            chan_en <= '0;
        end else if (wr_hit && avs_address == OFS_CHAN_ENABLE) begin
            chan_en <= chan_en | avs_writedata[NUM_CHANNELS-1:0]; // RULE_06
        end else if (wr_hit && avs_address == OFS_CHAN_DISABLE) begin
            chan_en <= chan_en & ~avs_writedata[NUM_CHANNELS-1:0]; // RULE_06
        end
    end

    // Read data register
    always_ff @(posedge clock) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && !rd_hold) begin
            case (avs_address)
                OFS_MODE: avs_readdata <= mode;
                OFS_CHANNEL_ENABLE_STATUS: avs_readdata <= {28'h000_0000, chan_en}; // RULE_08
                OFS_STATUS: avs_readdata <= {24'h00_0000, overrun, fifo_out_valid,
                    ~fifo_in_ready, (state != ST_IDLE), pending};
                OFS_LAST_RESULT: avs_readdata <= {18'h0_0000, 2'(last_chan), 2'h0, last_result};
                OFS_FIFO_DATA: avs_readdata <= {20'h0_0000, fifo_out_data};
                OFS_CHAN_RESULT0: avs_readdata <= {22'h00_0000, chan_result[0]};
                OFS_CHAN_RESULT0 + 8'h04: avs_readdata <= {22'h00_0000, chan_result[1]};
                OFS_CHAN_RESULT0 + 8'h08: avs_readdata <= {22'h00_0000, chan_result[2]};
                OFS_CHAN_RESULT0 + 8'h0C: avs_readdata <= {22'h00_0000, chan_result[3]};
                default: avs_readdata <= READ_UNMAPPED;
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge clock) begin
        if (reset || sw_reset) begin
            state <= ST_IDLE;
            pending <= '0;
            cur_chan <= '0;
            delay_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Triggers only accepted here; ignored mid-sequence
                    if (trigger && chan_en != '0) begin // RULE_11
                        pending <= chan_en; // RULE_06
                        delay_cnt <= 12'(mode[MODE_STARTUP_LSB +: 8]) * 12'(STARTUP_UNIT_CYCLES);
                        state <= ST_STARTUP; // RULE_10
                    end
                end
                ST_STARTUP: begin
                    // Startup wait only needed when the core was asleep
                    if (delay_cnt == '0 || !mode[MODE_SLEEP_BIT]) begin // RULE_07
                        state <= ST_SELECT;
                    end else begin
                        delay_cnt <= delay_cnt - 1'b1; // RULE_10
                    end
                end
                ST_SELECT: begin
                    if (pending == '0) begin
                        state <= ST_IDLE; // RULE_07
                    end else begin
                        for (int c = NUM_CHANNELS - 1; c >= 0; c--) begin
                            if (pending[c]) begin
                                cur_chan <= 2'(c); // RULE_05
                            end
                        end
                        delay_cnt <= 12'(mode[MODE_SHTIM_LSB +: 4]);
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (delay_cnt == '0) begin
                        state <= ST_CONVERT;
                    end else begin
                        delay_cnt <= delay_cnt - 1'b1; // RULE_10
                    end
                end
                ST_CONVERT: begin
                    if (core_done) begin
                        state <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    pending[cur_chan] <= 1'b0;
                    state <= ST_SELECT;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Core controls
    assign core_mux_select = cur_chan; // RULE_05
    assign core_power_on = !mode[MODE_SLEEP_BIT] || (state != ST_IDLE); // RULE_07
    assign core_sample = (state == ST_SAMPLE);
    assign core_start = (state == ST_CONVERT);

    // Resolution: 8-bit mode keeps the top eight bits
    assign next_result = mode[MODE_LOWRES_BIT]
        ? {2'b00, core_data[RES_HIGH_BITS-1 -: RES_LOW_BITS]} : core_data; // RULE_01

    // Result capture
    always_ff @(posedge clock) begin
        if (reset || sw_reset) begin
            last_result <= '0;
            last_chan <= '0;
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                chan_result[c] <= '0;
            end
        end else if (state == ST_CONVERT && core_done) begin
            last_result <= next_result; // RULE_02
            last_chan <= cur_chan;
            chan_result[cur_chan] <= next_result; // RULE_02
        end
    end

    // Overrun when the DMA FIFO is full, set wins over clear by status read
    always_ff @(posedge clock) begin
        if (reset || sw_reset) begin
            overrun <= 1'b0;
        end else if (state == ST_CONVERT && core_done && !fifo_in_ready) begin
            overrun <= 1'b1;
        end else if (avs_read && !rd_hold && avs_address == OFS_STATUS) begin
            overrun <= 1'b0;
        end
    end

    // Result FIFO feeding the DMA channel; bus data read also drains it
    adsq_fifo #(
        .WIDTH(12),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(state == ST_CONVERT && core_done), // RULE_09
        .in_ready(fifo_in_ready),
        .in_data({cur_chan, next_result}),
        .out_valid(fifo_out_valid),
        .out_ready(peripheral_dma_channel_ready || fifo_pop),
        .out_data(fifo_out_data)
    );
    assign peripheral_dma_channel_valid = fifo_out_valid; // RULE_09
    assign peripheral_dma_channel_data = fifo_out_data;

    // Assertions
    property p_status_tracks_enable;
        @(posedge clock) disable iff (reset)
        avs_read && !rd_hold && avs_address == OFS_CHANNEL_ENABLE_STATUS
            |=> avs_readdata == {28'h000_0000, $past(chan_en)};
    endproperty
    a_status_tracks_enable: assert property (p_status_tracks_enable) // RULE_08
        else $error("channel status mismatch");

    property p_result_both;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_CONVERT && core_done |=> last_result == chan_result[last_chan];
    endproperty
    a_result_both: assert property (p_result_both) // RULE_02
        else $error("result registers disagree");

    property p_lowres;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_CONVERT && core_done && mode[MODE_LOWRES_BIT] |=> last_result[9:8] == 2'b00;
    endproperty
    a_lowres: assert property (p_lowres) // RULE_01
        else $error("8-bit result wider than 8 bits");

    property p_only_enabled;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_SAMPLE |-> pending[cur_chan];
    endproperty
    a_only_enabled: assert property (p_only_enabled) // RULE_06
        else $error("disabled channel converted");

    property p_ignore_busy;
        @(posedge clock) disable iff (reset || sw_reset)
        (state == ST_SAMPLE || state == ST_CONVERT) && trigger |=> $stable(pending);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) // RULE_11
        else $error("trigger accepted mid-sequence");

    property p_ext_start;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_IDLE && mode[MODE_TRG_EN_BIT] && mode[3:1] == TRG_EXTERNAL
            && pin_rise[3] && chan_en != '0 |=> state == ST_STARTUP;
    endproperty
    a_ext_start: assert property (p_ext_start) // RULE_03
        else $error("external edge did not start");

    property p_sample_hold;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_SELECT && pending != '0 && mode[27:24] == 4'h2
            |=> core_sample [*3] ##1 core_start;
    endproperty
    a_sample_hold: assert property (p_sample_hold) // RULE_10
        else $error("sample-and-hold length wrong");

    property p_sleep_return;
        @(posedge clock) disable iff (reset || sw_reset)
        state == ST_SELECT && pending == '0 && mode[MODE_SLEEP_BIT] |=> !core_power_on;
    endproperty
    a_sleep_return: assert property (p_sleep_return) // RULE_07
        else $error("core not back asleep");

    property p_dma_push;
        @(posedge clock) disable iff (reset)
        state == ST_CONVERT && core_done && fifo_in_ready |=> fifo_out_valid;
    endproperty
    a_dma_push: assert property (p_dma_push) // RULE_09
        else $error("result not offered to DMA");
endmodule : adsq_control

// file: shared/adsq_pkg.sv
package adsq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CHAN_ENABLE = 8'h10;
    localparam logic [7:0] OFS_CHAN_DISABLE = 8'h14;
    localparam logic [7:0] OFS_CHANNEL_ENABLE_STATUS = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_LAST_RESULT = 8'h20;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h24;
    localparam logic [7:0] OFS_CHAN_RESULT0 = 8'h30;
    // Control register fields
    localparam int CTL_START_BIT = 1;
    localparam int CTL_SOFT_RESET_BIT = 0;
    // Mode register fields
    localparam int MODE_TRG_EN_BIT = 0;
    localparam int MODE_TRG_SEL_LSB = 1;
    localparam int MODE_LOWRES_BIT = 4;
    localparam int MODE_SLEEP_BIT = 5;
    localparam int MODE_STARTUP_LSB = 16;
    localparam int MODE_SHTIM_LSB = 24;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // Trigger source encodings
    localparam logic [2:0] TRG_TIMER0 = 3'h0;
    localparam logic [2:0] TRG_TIMER1 = 3'h1;
    localparam logic [2:0] TRG_TIMER2 = 3'h2;
    localparam logic [2:0] TRG_EXTERNAL = 3'h6;
    // Result widths and channel count
    localparam int RES_HIGH_BITS = 10;
    localparam int RES_LOW_BITS = 8;
    localparam int NUM_CHANNELS = 4;
    // Startup unit: startup field counts in multiples of this many clocks
    localparam int STARTUP_UNIT_CYCLES = 8;
    // Unmapped reads
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : adsq_pkg

// file: verilog/adsq_fifo.sv
`timescale 1ns/10ps
module adsq_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : adsq_fifo

// file: tb/adsq_core_model.sv
`timescale 1ns/10ps
module adsq_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Converter side of the control block
    input wire logic [1:0] core_mux_select,
    input wire logic core_power_on,
    input wire logic core_sample,
    input wire logic core_start,
    output logic core_done,
    output logic [9:0] core_data,
    // Bench control: analog level per input line and answer speed
    input wire logic [3:0][9:0] level,
    input wire logic slow
);
    logic [3:0] wait_count;
    logic answered;

    // Conversion timer; a powered-down core never answers
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_count <= 4'h0;
            answered <= 1'b0;
            core_done <= 1'b0;
            core_data <= 10'h155;
        end else begin
            core_done <= 1'b0;
            // Data toggle outside the done pulse so stale values never match
            core_data <= ~core_data;
            if (!core_start) begin
                wait_count <= 4'h0;
                answered <= 1'b0;
            end else if (core_power_on && !answered) begin
                if (wait_count == (slow ? 4'h9 : 4'h1)) begin
                    core_done <= 1'b1;
                    core_data <= level[core_mux_select];
                    answered <= 1'b1;
                end else begin
                    wait_count <= wait_count + 4'h1;
                end
            end
        end
    end
endmodule : adsq_core_model

// file: tb/adsq_control_bench.sv
`timescale 1ns/10ps
module adsq_control_bench
    import adsq_pkg::*;
;
    typedef struct {logic [31:0] value; logic [31:0] mask;} adsq_note_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_conv_trigger_pin = 1'b0;
    logic timer0_output_a = 1'b0;
    logic timer1_output_a = 1'b0;
    logic timer2_output_a = 1'b0;
    logic [1:0] core_mux_select;
    logic core_power_on, core_sample, core_start, core_done;
    logic [9:0] core_data;
    logic peripheral_dma_channel_valid;
    logic peripheral_dma_channel_ready = 1'b1;
    logic [11:0] peripheral_dma_channel_data;
    logic [3:0][9:0] level = '0;
    logic slow = 1'b0;
    adsq_note_t read_q[$];
    adsq_note_t note;
    logic [11:0] dma_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int done_count = 0;
    int sample_count = 0;
    int base, sbase, n, seed;
    logic [2:0] sel;

    adsq_control #(.FIFO_DEPTH(16)) uut (.clock(clock), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_conv_trigger_pin(ext_conv_trigger_pin), .timer0_output_a(timer0_output_a),
        .timer1_output_a(timer1_output_a), .timer2_output_a(timer2_output_a),
        .core_mux_select(core_mux_select), .core_power_on(core_power_on),
        .core_sample(core_sample), .core_start(core_start), .core_done(core_done),
        .core_data(core_data), .peripheral_dma_channel_valid(peripheral_dma_channel_valid),
        .peripheral_dma_channel_ready(peripheral_dma_channel_ready),
        .peripheral_dma_channel_data(peripheral_dma_channel_data));
    adsq_core_model core (.clock(clock), .reset(reset), .core_mux_select(core_mux_select),
        .core_power_on(core_power_on), .core_sample(core_sample), .core_start(core_start),
        .core_done(core_done), .core_data(core_data), .level(level), .slow(slow));

    // Clock, 8 ns period
    always #4 clock = ~clock;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    // Bus cycles: request after an edge, held until waitrequest is seen low
    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
        @(posedge clock);
        avs_address <= addr;
        avs_writedata <= data;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_write <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
        read_q.push_back('{exp, mask});
        @(posedge clock);
        avs_address <= addr;
        avs_read <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_read <= 1'b0;
    endtask : bus_read

    function automatic logic [9:0] res(input int ch, input logic low);
        return low ? {2'b00, level[ch][9:2]} : level[ch];
    endfunction : res

    task automatic expect_seq(input logic [3:0] en, input logic low);
        for (int c = 0; c < 4; c++) begin
            if (en[c]) begin
                dma_q.push_back({2'(c), res(c, low)});
            end
        end
    endtask : expect_seq

    task automatic new_levels();
        @(posedge clock);
        for (int c = 0; c < 4; c++) level[c] <= 10'($urandom);
        @(posedge clock);
    endtask : new_levels

    task automatic wait_done(input int from, input int count);
        for (int i = 0; i < 3000 && done_count < from + count; i++) @(posedge clock);
        check(done_count == from + count, "conversion count");
        repeat (6) @(posedge clock);
    endtask : wait_done

    task automatic wait_drain();
        for (int i = 0; i < 600 && dma_q.size() != 0; i++) @(posedge clock);
        check(dma_q.size() == 0, "dma words missing");
    endtask : wait_drain

    // Trigger pin pulse: rise, hold, fall
    task automatic pulse(input int which);
        repeat (2) begin
            @(posedge clock);
            case (which)
                0: timer0_output_a <= ~timer0_output_a;
                1: timer1_output_a <= ~timer1_output_a;
                2: timer2_output_a <= ~timer2_output_a;
                default: ext_conv_trigger_pin <= ~ext_conv_trigger_pin;
            endcase
            repeat (3) @(posedge clock);
        end
    endtask : pulse

    // Read data are taken at the edge that finds waitrequest low
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && read_q.size() != 0) begin
            note = read_q.pop_front();
            check((avs_readdata & note.mask) === (note.value & note.mask), "read data");
        end
    end

    // Watch the DMA stream and count core activity
    always @(posedge clock) begin
        if (peripheral_dma_channel_valid === 1'b1 && peripheral_dma_channel_ready === 1'b1) begin
            if (dma_q.size() == 0) check(1'b0, "unexpected dma word");
            else check(peripheral_dma_channel_data === dma_q.pop_front(), "dma word");
        end
        if (core_done === 1'b1) done_count++;
        if (core_sample === 1'b1) sample_count++;
    end

    // Watchdog
    initial begin
        #(8 * 40000);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        seed = $urandom(76);
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        bus_read(OFS_CHANNEL_ENABLE_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
        bus_read(OFS_MODE, MODE_RESET, 32'hFFFF_FFFF);
        bus_read(8'h40, READ_UNMAPPED, 32'hFFFF_FFFF);
        bus_write(OFS_CHAN_ENABLE, 32'h0000_000B, 4'hF);
        bus_write(OFS_CHAN_DISABLE, 32'h0000_0001, 4'hF);
        bus_write(OFS_CHAN_ENABLE, 32'h0000_0004, 4'h0);
        bus_write(OFS_CHANNEL_ENABLE_STATUS, 32'h0000_000F, 4'hF);
        bus_read(OFS_CHANNEL_ENABLE_STATUS, 32'h0000_000A, 32'hFFFF_FFFF);
        // Software start in both resolutions, fast and slow core
        for (int k = 0; k < 2; k++) begin
            new_levels();
            slow <= k[0];
            bus_write(OFS_MODE, 32'(k) << MODE_LOWRES_BIT, 4'hF);
            base = done_count;
            expect_seq(4'hA, k[0]);
            bus_write(OFS_CONTROL, 32'h0000_0002, 4'hF);
            wait_done(base, 2);
            wait_drain();
            bus_read(OFS_LAST_RESULT, {18'h0, 2'd3, 2'b00, res(3, k[0])}, 32'h0000_33FF);
            bus_read(OFS_CHAN_RESULT0 + 8'h04, {22'h0, res(1, k[0])}, 32'h0000_03FF);
            bus_read(OFS_CHAN_RESULT0 + 8'h0C, {22'h0, res(3, k[0])}, 32'h0000_03FF);
        end
        // Hardware sources: wrong source ignored, retrigger in a sequence ignored
        bus_write(OFS_CHAN_DISABLE, 32'h0000_000F, 4'hF);
        bus_write(OFS_CHAN_ENABLE, 32'h0000_0005, 4'hF);
        for (int s = 0; s < 4; s++) begin
            sel = (s == 3) ? TRG_EXTERNAL : 3'(s);
            new_levels();
            bus_write(OFS_MODE, (32'(sel) << MODE_TRG_SEL_LSB) | 32'h0000_0001, 4'hF);
            pulse((s + 1) % 4);
            repeat (20) @(posedge clock);
            base = done_count;
            expect_seq(4'h5, 1'b0);
            pulse(s);
            pulse(s);
            wait_done(base, 2);
            wait_drain();
        end
        // Sleep with startup and sample-and-hold delays
        slow <= 1'b0;
        bus_write(OFS_MODE, 32'h0202_0020, 4'hF);
        repeat (4) @(posedge clock);
        check(core_power_on === 1'b0, "core awake in sleep");
        base = done_count;
        sbase = sample_count;
        expect_seq(4'h5, 1'b0);
        bus_write(OFS_CONTROL, 32'h0000_0002, 4'hF);
        for (n = 0; n < 200 && core_sample !== 1'b1; n++) @(posedge clock);
        check(n >= 2 * STARTUP_UNIT_CYCLES, "startup too short");
        wait_done(base, 2);
        wait_drain();
        check(sample_count - sbase == 2 * 3, "sample-and-hold length");
        check(core_power_on === 1'b0, "core left awake");
        // Fill the FIFO against a stalled DMA until it refuses, then drain
        bus_write(OFS_MODE, MODE_RESET, 4'hF);
        bus_write(OFS_CHAN_ENABLE, 32'h0000_000F, 4'hF);
        peripheral_dma_channel_ready <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            base = done_count;
            if (r < 4) expect_seq(4'hF, 1'b0);
            bus_write(OFS_CONTROL, 32'h0000_0002, 4'hF);
            wait_done(base, 4);
        end
        bus_read(OFS_STATUS, 32'h0000_00E0, 32'h0000_00FF);
        bus_read(OFS_STATUS, 32'h0000_0060, 32'h0000_00FF);
        for (int i = 0; i < 600 && dma_q.size() != 0; i++) begin
            @(posedge clock);
            peripheral_dma_channel_ready <= 1'($urandom);
        end
        check(dma_q.size() == 0, "fifo not drained");
        @(posedge clock);
        peripheral_dma_channel_ready <= 1'b1;
        bus_read(OFS_STATUS, 32'h0000_0000, 32'h0000_00F0);
        // Soft reset clears the enables
        bus_write(OFS_CONTROL, 32'h0000_0001, 4'hF);
        bus_read(OFS_CHANNEL_ENABLE_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
        repeat (4) @(posedge clock);
        stop_test();
    end
endmodule : adsq_control_bench
